// [rtl/trsb_top.sv]
// Token ring serial bus controller with AHB-Lite register slave
`timescale 1ns/1ns
`include "trsb_map.svh"

module trsb_top #(
	parameter int RING_HALF = `TRSB_RING_HALF_CYC
) (
	input wire logic core_clk, // Core clock, 25 MHz
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	input wire logic token_in, // Token from previous node
	output logic token_out, // Token to next node
	input wire logic ring_data_in, // Data line level seen
	output logic ring_data_out, // Data line drive value
	output logic ring_data_oe, // Data line drive enable
	input wire logic ring_clk_in, // Ring clock line level seen
	output logic ring_clk_out, // Ring clock drive value
	output logic ring_clk_oe, // Ring clock drive enable
	output logic ring_interrupt // Level interrupt
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	initial begin
		if (RING_HALF < 1 || RING_HALF > 255) begin
			$error("RING_HALF out of range");
		end
	end

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rst_s1_ff; // First reset stage
	logic rst_n; // Released reset

	// Release reset through two flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n <= rst_s1_ff;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] clk_s1_ff; // First stage: clock, token, data
	logic [2:0] clk_s2_ff; // Second stage
	logic ext_clk_d_ff; // Delayed clock for edge find
	logic token_sync; // Synced token in
	logic data_sync; // Synced data line

	// Two flops on every ring input: clock, token, data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_s1_ff <= 3'h0;
			clk_s2_ff <= 3'h0;
			ext_clk_d_ff <= 1'b0;
		end else begin
			clk_s1_ff <= {ring_clk_in, token_in, ring_data_in};
			clk_s2_ff <= clk_s1_ff;
			ext_clk_d_ff <= clk_s2_ff[2];
		end
	end
	assign token_sync = clk_s2_ff[1];
	assign data_sync = clk_s2_ff[0];

	// ----------------------------------------------------------------
	// Control flags and ring clock source
	// ----------------------------------------------------------------
	trsb_pkg::trsb_flags_t flags_ff; // Control and status flags
	logic [7:0] div_cnt_ff; // Ring clock divider count
	logic div_ff; // Generated ring clock
	logic div_rise; // Generated clock rising
	logic ring_rise; // Selected ring clock rising

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_ff <= 8'h00;
			div_ff <= 1'b0;
		end else if (div_cnt_ff == 8'(RING_HALF - 1)) begin
			div_cnt_ff <= 8'h00;
			div_ff <= ~div_ff;
		end else begin
			div_cnt_ff <= div_cnt_ff + 8'h01;
		end
	end
	assign div_rise = (div_cnt_ff == 8'(RING_HALF - 1)) && !div_ff;
	// own clock used directly, no crossing
	assign ring_rise = flags_ff.clk_en ? div_rise : (clk_s2_ff[2] && !ext_clk_d_ff);
	assign ring_clk_out = div_ff;
	// drive clock line only when enabled
	assign ring_clk_oe = flags_ff.clk_en;

	// ----------------------------------------------------------------
	// Timing state counter and decoder
	// ----------------------------------------------------------------
	logic [5:0] state_ff; // Timing state 0..37
	logic [7:0] state_dec; // Decoded timing state

	// advance on ring clock rise, wrap after 37
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= `TRSB_RST_STATE;
		end else if (ring_rise) begin
			state_ff <= (state_ff == `TRSB_ST_LAST) ? 6'h00 : state_ff + 6'h01;
		end
	end

	// one-hot decode, bit 7 stays zero
	always_comb begin
		state_dec = 8'h00;
		if (state_ff < `TRSB_ST_SHIFT_FIRST) begin
			state_dec[state_ff[1:0]] = 1'b1;
		end else if (state_ff <= `TRSB_ST_SHIFT_LAST) begin
			state_dec[3] = 1'b1;
		end else if (state_ff == `TRSB_ST_ADDR) begin
			state_dec[4] = 1'b1;
		end else if (state_ff == `TRSB_ST_ACK) begin
			state_dec[5] = 1'b1;
		end else begin
			state_dec[6] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	trsb_pkg::trsb_aphase_t aph_ff; // Pending data phase
	logic take; // Address phase accepted
	logic hit; // Address inside block
	logic [31:0] rd_word; // Read data for this address
	logic [31:0] msg_ff; // Message shift register
	logic [2:0] node_addr_ff; // Own ring address
	logic bus_en_ff; // Ring bus enable
	logic [2:0] istat_ff; // Sticky interrupt status
	logic [2:0] imask_ff; // Interrupt mask
	logic rd_msg3; // Read of message byte 3
	logic wr_msg0; // Write of message byte 0
	logic wr_go; // Write data phase ends now

	assign take = hsel && htrans[1] && hready;
	assign hit = (haddr[31:8] == 24'h000000);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// read-only state, sync lag
	// Read mux, unmapped reads give zero
	always_comb begin
		rd_word = 32'h00000000;
		if (hit) begin
			unique case (haddr[7:0])
				`TRSB_OFF_STATE: rd_word = {24'h000000, state_dec};
				`TRSB_OFF_MSG0: rd_word = {24'h000000, msg_ff[7:0]};
				`TRSB_OFF_MSG1: rd_word = {24'h000000, msg_ff[15:8]};
				`TRSB_OFF_MSG2: rd_word = {24'h000000, msg_ff[23:16]};
				`TRSB_OFF_MSG3: rd_word = {24'h000000, msg_ff[31:24]};
				`TRSB_OFF_CTRL: rd_word = {25'h0000000, flags_ff.clk_en, 1'b0, flags_ff.recv,
					flags_ff.nack, 1'b0, flags_ff.master, flags_ff.send};
				`TRSB_OFF_CFG: rd_word = {28'h0000000, node_addr_ff, bus_en_ff};
				`TRSB_OFF_ISTAT: rd_word = {29'h00000000, istat_ff};
				`TRSB_OFF_IMASK: rd_word = {29'h00000000, imask_ff};
				default: rd_word = 32'h00000000;
			endcase
		end
	end

	// Capture address phase and read data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aph_ff <= '0;
			hrdata <= 32'h00000000;
		end else begin
			aph_ff <= '{valid: take && hit, write: hwrite, addr: haddr[7:0]};
			if (take && !hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	assign wr_go = aph_ff.valid && aph_ff.write;
	// read side effect taken with the address phase
	assign rd_msg3 = take && hit && !hwrite && (haddr[7:0] == `TRSB_OFF_MSG3);
	// write side effect taken with the data phase
	assign wr_msg0 = wr_go && (aph_ff.addr == `TRSB_OFF_MSG0);

	// Configuration and mask registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_en_ff <= 1'b0;
			node_addr_ff <= 3'h0;
			imask_ff <= `TRSB_RST_IMASK;
		end else if (wr_go && aph_ff.addr == `TRSB_OFF_CFG) begin
			bus_en_ff <= hwdata[`TRSB_CFG_BUSEN];
			node_addr_ff <= hwdata[`TRSB_CFG_ADDR_LSB +: 3];
		end else if (wr_go && aph_ff.addr == `TRSB_OFF_IMASK) begin
			imask_ff <= hwdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// Frame roles and ring events
	// ----------------------------------------------------------------
	trsb_pkg::trsb_role_t role_ff; // Role in this frame
	logic token_ff; // Token held this frame
	logic seed_ff; // One-shot token injection
	logic start_ff; // Listener saw start marker
	logic addr_match; // Received frame is ours
	logic ev_master; // Frame sent and acknowledged
	logic ev_nack; // Frame sent, no acknowledge
	logic ev_recv; // Frame received for us

	assign addr_match = (msg_ff[31:29] == node_addr_ff);
	assign ev_master = ring_rise && state_ff == `TRSB_ST_ACK && role_ff == trsb_pkg::TRSB_TALK
		&& !data_sync;
	assign ev_nack = ring_rise && state_ff == `TRSB_ST_ACK && role_ff == trsb_pkg::TRSB_TALK
		&& data_sync;
	// destination from top three message bits
	assign ev_recv = ring_rise && state_ff == `TRSB_ST_ADDR && role_ff == trsb_pkg::TRSB_LISTEN
		&& start_ff && addr_match;

	// token capture at frame start and role choice
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			role_ff <= trsb_pkg::TRSB_IDLE;
			token_ff <= 1'b0;
			seed_ff <= 1'b0;
		end else begin
			if (wr_go && aph_ff.addr == `TRSB_OFF_CFG && hwdata[`TRSB_CFG_SEED]) begin
				seed_ff <= 1'b1;
			end else if (ring_rise && state_ff == `TRSB_ST_LAST) begin
				seed_ff <= 1'b0;
			end
			if (ring_rise && state_ff == `TRSB_ST_LAST) begin
				token_ff <= token_sync || seed_ff;
				if ((token_sync || seed_ff) && flags_ff.send && bus_en_ff) begin
					role_ff <= trsb_pkg::TRSB_TALK;
				end else if (!flags_ff.send && !flags_ff.recv && bus_en_ff) begin
					role_ff <= trsb_pkg::TRSB_LISTEN;
				end else begin
					role_ff <= trsb_pkg::TRSB_IDLE;
				end
			end
		end
	end

	// pass token on during the last state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			token_out <= 1'b0;
		end else if (ring_rise && state_ff == `TRSB_ST_ACK) begin
			token_out <= token_ff;
		end else if (ring_rise && state_ff == 6'h00) begin
			token_out <= 1'b0;
		end
	end

	// Listener start marker, low data in state 2
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_ff <= 1'b0;
		end else if (ring_rise && state_ff == `TRSB_ST_START) begin
			start_ff <= !data_sync;
		end
	end

	// ----------------------------------------------------------------
	// Message shift register
	// ----------------------------------------------------------------
	logic shift_now; // Bit edge of states 3..34

	assign shift_now = ring_rise && state_ff >= `TRSB_ST_SHIFT_FIRST
		&& state_ff <= `TRSB_ST_SHIFT_LAST;

	// host byte access and one bit per shift state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			msg_ff <= 32'h00000000;
		end else if (shift_now && role_ff == trsb_pkg::TRSB_TALK) begin
			msg_ff <= {msg_ff[30:0], msg_ff[31]};
		end else if (shift_now && role_ff == trsb_pkg::TRSB_LISTEN && start_ff) begin
			msg_ff <= {msg_ff[30:0], data_sync};
		end else if (wr_go) begin
			unique case (aph_ff.addr)
				`TRSB_OFF_MSG0: msg_ff[7:0] <= hwdata[7:0];
				`TRSB_OFF_MSG1: msg_ff[15:8] <= hwdata[7:0];
				`TRSB_OFF_MSG2: msg_ff[23:16] <= hwdata[7:0];
				`TRSB_OFF_MSG3: msg_ff[31:24] <= hwdata[7:0];
				default: msg_ff <= msg_ff;
			endcase
		end
	end

	// Data line drive: start, message bits, acknowledge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ring_data_out <= 1'b0;
			ring_data_oe <= 1'b0;
		end else if (ring_rise) begin
			ring_data_out <= 1'b0;
			ring_data_oe <= 1'b0;
			if (role_ff == trsb_pkg::TRSB_TALK && state_ff == 6'h01) begin
				ring_data_oe <= 1'b1;
			end else if (role_ff == trsb_pkg::TRSB_TALK && state_ff == `TRSB_ST_START) begin
				ring_data_out <= msg_ff[31];
				ring_data_oe <= 1'b1;
			end else if (role_ff == trsb_pkg::TRSB_TALK && state_ff >= `TRSB_ST_SHIFT_FIRST
				&& state_ff < `TRSB_ST_SHIFT_LAST) begin
				ring_data_out <= msg_ff[30];
				ring_data_oe <= 1'b1;
			end else if (ev_recv) begin
				ring_data_oe <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control and status flags
	// ----------------------------------------------------------------
	// flags, hardware set wins over clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff <= '0;
		end else begin
			if (wr_go && aph_ff.addr == `TRSB_OFF_CTRL && hwdata[`TRSB_CTRL_SEND]) begin
				flags_ff.send <= 1'b1;
			end else if (wr_msg0) begin
				flags_ff.send <= 1'b0;
			end
			if (wr_go && aph_ff.addr == `TRSB_OFF_CTRL) begin
				flags_ff.clk_en <= hwdata[`TRSB_CTRL_CLKEN];
			end
			if (ev_master) begin
				flags_ff.master <= 1'b1;
			end else if (wr_go && aph_ff.addr == `TRSB_OFF_CTRL && hwdata[`TRSB_CTRL_MASTER]) begin
				flags_ff.master <= 1'b0;
			end
			if (ev_nack) begin
				flags_ff.nack <= 1'b1;
			end else if (wr_go && aph_ff.addr == `TRSB_OFF_CTRL && hwdata[`TRSB_CTRL_NACK]) begin
				flags_ff.nack <= 1'b0;
			end
			if (ev_recv) begin
				flags_ff.recv <= 1'b1;
			end else if (rd_msg3) begin
				flags_ff.recv <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	logic [2:0] ev_vec; // Events in status bit order

	assign ev_vec = {ev_recv, ev_nack, ev_master};

	// Sticky status, write one to clear, event wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			istat_ff <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (ev_vec[i]) begin
					istat_ff[i] <= 1'b1;
				end else if (wr_go && aph_ff.addr == `TRSB_OFF_ISTAT && hwdata[i]) begin
					istat_ff[i] <= 1'b0;
				end
			end
		end
	end

	// interrupt gated by bus enable and mask
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ring_interrupt <= 1'b0;
		end else begin
			ring_interrupt <= bus_en_ff && |(istat_ff & imask_ff);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_state_onehot: assert property (@(posedge core_clk) disable iff (!rst_n) $onehot(state_dec))
		else $error("state decode not one-hot");
	a_state_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
		ring_rise && state_ff == `TRSB_ST_LAST |=> state_ff == 6'h00)
		else $error("state did not wrap to 0");
	a_state_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		ring_rise && state_ff != `TRSB_ST_LAST |=> state_ff == $past(state_ff) + 6'h01)
		else $error("state did not step by one");
	a_state_write_ro: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ring_rise |=> $stable(state_ff))
		else $error("state moved without ring clock");
	a_mid_span_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff >= `TRSB_ST_SHIFT_FIRST && state_ff <= `TRSB_ST_SHIFT_LAST |-> state_dec == 8'h08)
		else $error("mid span decode wrong");
	a_recv_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_msg3 && !ev_recv |=> !flags_ff.recv)
		else $error("receive pending not cleared");
	a_send_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_msg0 && !(wr_go && aph_ff.addr == `TRSB_OFF_CTRL) |=> !flags_ff.send)
		else $error("send pending not cleared");
	a_irq_raise: assert property (@(posedge core_clk) disable iff (!rst_n)
		ev_recv && bus_en_ff && imask_ff[2] |=> ##1 ring_interrupt)
		else $error("interrupt missing after receive");
	a_clk_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		flags_ff.clk_en && ring_rise |=> ring_clk_oe && ring_clk_out && !$past(ring_clk_out))
		else $error("driven clock not rising with state");
	a_talk_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		ring_rise && state_ff == `TRSB_ST_START && role_ff == trsb_pkg::TRSB_TALK
		|=> ring_data_oe [*8])
		else $error("talker stopped driving data");
	a_token_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
		ring_rise && state_ff == `TRSB_ST_ACK && token_ff |=> token_out)
		else $error("token not passed on");

endmodule

// [rtl/trsb_map.svh]
// Register offsets, field positions, reset values and timing counts of the token ring bus
`ifndef TRSB_MAP_SVH
`define TRSB_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TRSB_OFF_STATE 8'h14
`define TRSB_OFF_MSG0 8'h18
`define TRSB_OFF_MSG1 8'h1c
`define TRSB_OFF_MSG2 8'h20
`define TRSB_OFF_MSG3 8'h24
`define TRSB_OFF_CTRL 8'h28
`define TRSB_OFF_CFG 8'h2c
`define TRSB_OFF_ISTAT 8'h30
`define TRSB_OFF_IMASK 8'h34

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TRSB_CTRL_SEND 0
`define TRSB_CTRL_MASTER 1
`define TRSB_CTRL_NACK 3
`define TRSB_CTRL_RECV 4
`define TRSB_CTRL_CLKEN 6
`define TRSB_CFG_BUSEN 0
`define TRSB_CFG_ADDR_LSB 1
`define TRSB_CFG_SEED 4
`define TRSB_IRQ_MASTER 0
`define TRSB_IRQ_NACK 1
`define TRSB_IRQ_RECV 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TRSB_RST_CTRL 8'h00
`define TRSB_RST_STATE 6'h00
`define TRSB_RST_IMASK 3'h7

// ----------------------------------------------------------------
// Timing states and clock figures
// ----------------------------------------------------------------
`define TRSB_ST_START 6'h02
`define TRSB_ST_SHIFT_FIRST 6'h03
`define TRSB_ST_SHIFT_LAST 6'h22
`define TRSB_ST_ADDR 6'h23
`define TRSB_ST_ACK 6'h24
`define TRSB_ST_LAST 6'h25
`define TRSB_CORE_CLK_NS 40
`define TRSB_RING_CLK_NS 320
`define TRSB_RING_HALF_CYC (`TRSB_RING_CLK_NS / (2 * `TRSB_CORE_CLK_NS))

`endif

// [rtl/trsb_pkg.sv]
// Types shared by the token ring bus controller
package trsb_pkg;

	// Software visible control and status flags
	typedef struct packed {
		logic clk_en;
		logic recv;
		logic nack;
		logic master;
		logic send;
	} trsb_flags_t;

	// Captured AHB address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} trsb_aphase_t;

	// Part this node plays in the current frame
	typedef enum logic [1:0] {
		TRSB_IDLE = 2'b00,
		TRSB_TALK = 2'b01,
		TRSB_LISTEN = 2'b10
	} trsb_role_t;

endpackage

// [bench/trsb_peer.sv]
// Behavioural peer node that faces the controller across the ring
`timescale 1ns/1ns

module trsb_peer (
	output logic ring_clk, // Ring clock made by this node
	output logic data_oe, // Data line drive enable
	output logic data_out, // Data line drive value
	input wire logic data_in, // Resolved data line level
	output logic token, // Token towards the controller
	input wire logic token_back // Token from the controller
);
	logic [5:0] st; // Timing state of this node
	logic [31:0] tx; // Message this node sends
	logic [31:0] rx; // Message shifted in from the line
	logic talk; // Send tx in the coming frame
	logic give; // Hand the token over at state 37
	logic ack_en; // Pull the line low in state 36
	logic ack; // Line level seen low in state 36
	logic tok_seen; // Token seen from the controller

	initial begin
		{ring_clk, data_oe, token, talk, give, ack_en} = '0;
		data_out = 1'b1;
		st = 6'h00;
		tx = '0;
	end

	// Clock stands low between bursts, 320 ns per tick
	task automatic run(input int n);
		#13;
		repeat (n) begin
			ring_clk = 1'b1;
			#160;
			ring_clk = 1'b0;
			#160;
		end
	endtask

	always @(posedge ring_clk) begin
		if (st >= 6'h03 && st <= 6'h22) begin
			rx <= {rx[30:0], data_in};
		end
		if (st == 6'h24) begin
			ack <= !data_in;
		end
		if (st == 6'h25) begin
			tok_seen <= token_back;
		end
		st <= (st == 6'h25) ? 6'h00 : st + 6'h01;
	end

	always @(negedge ring_clk) begin
		token <= give && st == 6'h25;
		data_oe <= (talk && st >= 6'h02 && st <= 6'h22) || (ack_en && st == 6'h24);
		data_out <= (talk && st >= 6'h03 && st <= 6'h22) ? tx[6'h22 - st] : 1'b0;
	end
endmodule

// [bench/tb.sv]
// Self-checking bench for the token ring serial bus controller
`timescale 1ns/1ns
`include "trsb_map.svh"

module tb;
	logic core_clk, rstn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, msg, m2;
	logic [1:0] htrans;
	logic [2:0] hsize, node;
	logic token_out, ring_data_out, ring_data_oe, ring_clk_out, ring_clk_oe, ring_interrupt;
	logic p_clk, p_oe, p_out, p_tok, data_line, clk_line, b;
	logic rd_ph = 1'b0; // Read data phase pending
	logic [31:0] exp_q[$]; // Expected read data, oldest first
	int fail_count, num_checks, seed, i;

	// Pulled-up data line, clock from whoever drives it
	assign data_line = !(ring_data_oe && !ring_data_out) && !(p_oe && !p_out);
	assign clk_line = ring_clk_oe ? ring_clk_out : p_clk;

	trsb_top #(.RING_HALF(4)) i_dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.token_in(p_tok), .token_out(token_out), .ring_data_in(data_line),
		.ring_data_out(ring_data_out), .ring_data_oe(ring_data_oe), .ring_clk_in(clk_line),
		.ring_clk_out(ring_clk_out), .ring_clk_oe(ring_clk_oe),
		.ring_interrupt(ring_interrupt));

	trsb_peer i_peer (.ring_clk(p_clk), .data_oe(p_oe), .data_out(p_out),
		.data_in(data_line), .token(p_tok), .token_back(token_out));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// Compare, bus and sequencing tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// One single AHB-Lite transfer, zero or more wait states
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	// Read monitor pops the oldest note at each read data phase
	always @(posedge core_clk) begin
		if (rd_ph && hreadyout) begin
			chk(hrdata, exp_q.pop_front());
			chk_bit(hresp, 1'b0);
		end
		if (hreadyout) begin
			rd_ph <= hsel && htrans == 2'h2 && !hwrite;
		end
	end

	function automatic logic [31:0] st_exp(input logic [5:0] n);
		if (n < 6'h03) return 32'h1 << n;
		if (n <= 6'h22) return 32'h8;
		return 32'h1 << (n - 6'h1f);
	endfunction

	task automatic to_state(input logic [5:0] s);
		while (i_peer.st != s) i_peer.run(1);
	endtask

	// Token offered before the frame, then one whole frame
	task automatic frame(input logic g, input logic a, input logic t);
		to_state(6'h01);
		i_peer.give = g;
		to_state(6'h00);
		i_peer.give = 1'b0;
		i_peer.ack_en = a;
		i_peer.talk = t;
		i_peer.run(38);
		i_peer.ack_en = 1'b0;
		i_peer.talk = 1'b0;
	endtask

	task automatic conclude();
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		fail_count++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h0940;
		{rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(`TRSB_OFF_STATE, 32'h1);
		rd(`TRSB_OFF_CTRL, 32'h0);
		rd(`TRSB_OFF_IMASK, 32'h7);
		wr(`TRSB_OFF_STATE, 32'hff);
		rd(`TRSB_OFF_STATE, 32'h1);
		rd(8'h80, 32'h0);
		// Walk the whole state cycle and past the wrap
		for (i = 0; i < 40; i++) begin
			i_peer.run(1);
			rd(`TRSB_OFF_STATE, st_exp(i_peer.st));
		end
		// Send a random message, acknowledged by the peer
		node = 3'($random(seed));
		msg = $random(seed);
		wr(`TRSB_OFF_CFG, {28'h0, node, 1'b1});
		for (i = 0; i < 4; i++) wr(`TRSB_OFF_MSG0 + 8'(4 * i), {24'h0, msg[8 * i +: 8]});
		wr(`TRSB_OFF_CTRL, 32'h1);
		rd(`TRSB_OFF_CTRL, 32'h1);
		frame(1'b1, 1'b1, 1'b0);
		chk(i_peer.rx, msg);
		chk_bit(i_peer.tok_seen, 1'b1);
		rd(`TRSB_OFF_MSG3, {24'h0, msg[31:24]});
		rd(`TRSB_OFF_ISTAT, 32'h1);
		chk_bit(ring_interrupt, 1'b1);
		wr(`TRSB_OFF_IMASK, 32'h0);
		repeat (2) @(posedge core_clk);
		chk_bit(ring_interrupt, 1'b0);
		wr(`TRSB_OFF_IMASK, 32'h7);
		wr(`TRSB_OFF_ISTAT, 32'h1);
		wr(`TRSB_OFF_CTRL, 32'ha);
		repeat (2) @(posedge core_clk);
		chk_bit(ring_interrupt, 1'b0);
		rd(`TRSB_OFF_ISTAT, 32'h0);
		// Peer stays silent, so the message is not acknowledged
		wr(`TRSB_OFF_CTRL, 32'h1);
		frame(1'b1, 1'b0, 1'b0);
		rd(`TRSB_OFF_ISTAT, 32'h2);
		wr(`TRSB_OFF_ISTAT, 32'h2);
		wr(`TRSB_OFF_CTRL, 32'ha);
		wr(`TRSB_OFF_CTRL, 32'h1);
		rd(`TRSB_OFF_CTRL, 32'h1);
		wr(`TRSB_OFF_MSG0, 32'h0);
		rd(`TRSB_OFF_CTRL, 32'h0);
		// Peer talks to this node
		m2 = $random(seed);
		m2[31:29] = node;
		i_peer.tx = m2;
		frame(1'b0, 1'b0, 1'b1);
		chk_bit(i_peer.ack, 1'b1);
		rd(`TRSB_OFF_CTRL, 32'h10);
		rd(`TRSB_OFF_ISTAT, 32'h4);
		for (i = 0; i < 4; i++) rd(`TRSB_OFF_MSG0 + 8'(4 * i), {24'h0, m2[8 * i +: 8]});
		rd(`TRSB_OFF_CTRL, 32'h0);
		// Software injects the token, peer acknowledges the echoed message
		wr(`TRSB_OFF_CTRL, 32'h1);
		wr(`TRSB_OFF_CFG, {27'h0, 1'b1, node, 1'b1});
		frame(1'b0, 1'b1, 1'b0);
		chk(i_peer.rx, m2);
		chk_bit(i_peer.tok_seen, 1'b1);
		rd(`TRSB_OFF_ISTAT, 32'h5);
		wr(`TRSB_OFF_MSG0, 32'h0);
		wr(`TRSB_OFF_CTRL, 32'h2);
		rd(`TRSB_OFF_CTRL, 32'h0);
		// Node drives the ring clock from its own core clock
		wr(`TRSB_OFF_CTRL, 32'h40);
		rd(`TRSB_OFF_CTRL, 32'h40);
		repeat (2) @(posedge core_clk);
		chk_bit(ring_clk_oe, 1'b1);
		b = ring_clk_out;
		repeat (4) @(posedge core_clk);
		chk_bit(ring_clk_out, !b);
		conclude();
	end
endmodule
